// ### design/scw_serial_config.sv
// serial configuration write port with its write-only register set
//
// How it works
// R1: port active only in extended control mode
// R2: registers are write only, no readback
// R3: host holds select low during access
// R4: sample data on rising serial clock edges
// R5: frame is 32 bits, msb first
// R6: header is eleven zeros then one
// R7: four address bits follow, msb first
// R8: last sixteen bits become register contents
// R9: 33rd edge starts next frame
// R10: select may stay low permanently
// R11: host avoids writes during calibration
// R12: decode addresses 1h,2h,3h,Dh,Eh,Fh; others reserved
// R13: registers inert in normal control mode
// R14: contents held during power down
// R15: host writes fixed-one configuration bits
// R16: config bit 14 selects differential clock reset
// R17: config bit 13 disables termination trim
// R18: config bit 12 enables duty stabilizer
// R19: config bit 11 sets double-rate strobe phase
// R20: config bit 10 selects single rate
// R21: config bit 8 selects output edge
// R22: offset magnitude bits 15:8, sign bit 7
// R23: mode comes from fixed mode pin
// R24: coarse bit 15 enables phase adjust
// R25: discard frames with a bad header
// R26: early select release abandons the frame
`timescale 1ns/10ps

module scw_serial_config #(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // serial pins, asynchronous to clk_i
  input  wire logic                    serial_select_n_i,
  input  wire logic                    serial_clk_i,
  input  wire logic                    serial_data_in_i,
  // device mode and power pins
  input  wire logic                    extended_mode_i,
  input  wire logic                    power_down_i,
  // normal control mode pin settings
  input  wire scw_pkg::scw_pins_t      normal_pins_i,
  // effective settings to the converter core
  output logic [15:0]                  full_scale_o,
  output logic [15:0]                  fine_phase_o,
  output logic [15:0]                  coarse_phase_o,
  output logic [15:0]                  capture_buffer_o,
  output scw_pkg::scw_settings_t       settings_o,
  // one-cycle pulse on every accepted write
  output logic                         write_pulse_o
);

  initial begin
    if (SYNC_STAGES != 2) $error("scw_serial_config: SYNC_STAGES must be 2");
    if (scw_pkg::HDR_BITS + scw_pkg::ADDR_BITS + scw_pkg::DATA_BITS != scw_pkg::FRAME_BITS) begin
      $error("scw_serial_config: header, address and data must fill the frame");
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // only the second stage is read; edges come from comparing it to a third
  logic [1:0] sel_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] mode_sync_q;
  logic       sck_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_sync_q  <= 2'h3;
      sck_sync_q  <= 2'h0;
      sda_sync_q  <= 2'h0;
      sck_prev_q  <= 1'b0;
    end else begin
      sel_sync_q  <= {sel_sync_q[0], serial_select_n_i};
      sck_sync_q  <= {sck_sync_q[0], serial_clk_i};
      sda_sync_q  <= {sda_sync_q[0], serial_data_in_i};
      sck_prev_q  <= sck_sync_q[1];
    end
  end

  // runs through reset, so the capture right after release sees the strap itself
  always_ff @(posedge clk_i) begin
    mode_sync_q <= {mode_sync_q[0], extended_mode_i};
  end

  logic sel_active;
  logic sck_rise;
  logic sda_bit;
  logic ext_mode;

  assign sel_active = ~sel_sync_q[1];
  assign sck_rise   = sck_sync_q[1] & ~sck_prev_q;   // [R4]
  assign sda_bit    = sda_sync_q[1];

  // ----------------------------------------------------------------
  // control mode capture
  // ----------------------------------------------------------------
  // the mode pin is a fixed strap: sampled once after reset release
  logic mode_taken_q;
  logic ext_mode_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_taken_q <= 1'b0;
      ext_mode_q   <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_taken_q <= 1'b1;
      ext_mode_q   <= mode_sync_q[1];                  // [R23]
    end
  end

  // the first cycle after reset still waits for the strap
  assign ext_mode = ext_mode_q & mode_taken_q;

  // ----------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------
  // no timeout anywhere: the serial clock may be arbitrarily slow
  logic [31:0] shift_q;
  logic [5:0]  bit_cnt_q;
  logic        frame_done;
  logic [31:0] frame_word;

  assign frame_done = sck_rise & sel_active & ext_mode
                      & (bit_cnt_q == 6'(scw_pkg::FRAME_BITS - 1));
  assign frame_word = {shift_q[30:0], sda_bit};       // [R5]

  // no clear between frames: 32 shifts replace every stale bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= 32'h0000_0000;
    end else if (ext_mode && sel_active && sck_rise) begin
      shift_q <= frame_word;                           // [R4] [R5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_q <= 6'h00;
    end else if (!ext_mode || !sel_active) begin
      bit_cnt_q <= 6'h00;                              // [R1] [R26]
    end else if (frame_done) begin
      bit_cnt_q <= 6'h00;                              // [R9]
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  logic [11:0] frame_hdr;
  logic [3:0]  frame_addr;
  logic [15:0] frame_data;
  logic        frame_ok;

  assign frame_hdr  = frame_word[31:20];               // [R6]
  assign frame_addr = frame_word[19:16];               // [R7]
  assign frame_data = frame_word[15:0];                // [R8]
  assign frame_ok   = frame_done && (frame_hdr == scw_pkg::HDR_PATTERN); // [R25]

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] target);
    addr_hit = (a == target);
  endfunction

  // ----------------------------------------------------------------
  // register set
  // ----------------------------------------------------------------
  // write only; power down does not touch them, only rst_i does
  logic [15:0] config_q;
  logic [15:0] offset_q;
  logic [15:0] fullsc_q;
  logic [15:0] fine_q;
  logic [15:0] coarse_q;
  logic [15:0] capbuf_q;
  logic        write_q;

  // one write enable per register; reserved addresses leave all of them low
  logic [5:0] wr_sel;

  always_comb begin
    wr_sel = 6'h00;
    if (!frame_ok) begin
      wr_sel = 6'h00;                                  // [R25]
    end else if (addr_hit(frame_addr, scw_pkg::ADDR_CONFIG)) begin
      wr_sel = 6'h01;                                  // [R12]
    end else if (addr_hit(frame_addr, scw_pkg::ADDR_OFFSET)) begin
      wr_sel = 6'h02;                                  // [R12]
    end else if (addr_hit(frame_addr, scw_pkg::ADDR_FULLSCL)) begin
      wr_sel = 6'h04;                                  // [R12]
    end else if (addr_hit(frame_addr, scw_pkg::ADDR_FINE_PH)) begin
      wr_sel = 6'h08;                                  // [R12]
    end else if (addr_hit(frame_addr, scw_pkg::ADDR_COARS_PH)) begin
      wr_sel = 6'h10;                                  // [R12]
    end else if (addr_hit(frame_addr, scw_pkg::ADDR_CAPBUF)) begin
      wr_sel = 6'h20;                                  // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_q <= scw_pkg::CONFIG_RESET;
    end else if (wr_sel[0]) begin                      // [R14]
      config_q <= frame_data;                          // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_q <= scw_pkg::OFFSET_RESET;
    end else if (wr_sel[1]) begin
      offset_q <= frame_data;                          // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fullsc_q <= scw_pkg::FULLSC_RESET;
    end else if (wr_sel[2]) begin
      fullsc_q <= frame_data;                          // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fine_q <= scw_pkg::FINE_RESET;
    end else if (wr_sel[3]) begin
      fine_q <= frame_data;                            // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coarse_q <= scw_pkg::COARSE_RESET;
    end else if (wr_sel[4]) begin
      coarse_q <= frame_data;                          // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capbuf_q <= scw_pkg::CAPBUF_RESET;
    end else if (wr_sel[5]) begin
      capbuf_q <= frame_data;                          // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_q <= 1'b0;
    end else begin
      write_q <= frame_ok;
    end
  end

  // ----------------------------------------------------------------
  // effective settings
  // ----------------------------------------------------------------
  // in normal mode the pins set single rate and output edge, the rest is fixed; register values are ignored
  scw_pkg::scw_settings_t set_d;
  scw_pkg::scw_settings_t set_q;

  always_comb begin
    set_d.diff_clkreset_enable     = config_q[scw_pkg::CFG_DIFF_RST_BIT];  // [R16]
    set_d.termination_trim_disable = config_q[scw_pkg::CFG_TRIM_DIS_BIT];  // [R17]
    set_d.duty_cycle_stabilize     = config_q[scw_pkg::CFG_DUTY_STAB_BIT]; // [R18]
    set_d.double_rate_strobe_phase = config_q[scw_pkg::CFG_DDR_PHASE_BIT]; // [R19]
    set_d.single_rate_select       = config_q[scw_pkg::CFG_SDR_SEL_BIT];   // [R20]
    set_d.output_edge              = config_q[scw_pkg::CFG_OUT_EDGE_BIT];  // [R21]
    set_d.offset_magnitude         = offset_q[15:scw_pkg::OFS_MAG_LSB];    // [R22]
    set_d.offset_negative          = offset_q[scw_pkg::OFS_SIGN_BIT];      // [R22]
    set_d.phase_adjust_enable      = coarse_q[scw_pkg::CRS_ENABLE_BIT];    // [R24]
    if (!ext_mode) begin                                                   // [R13]
      set_d.diff_clkreset_enable     = 1'b0;
      set_d.termination_trim_disable = 1'b0;
      set_d.duty_cycle_stabilize     = 1'b1;
      set_d.double_rate_strobe_phase = 1'b0;
      set_d.single_rate_select       = normal_pins_i.single_rate_select;
      set_d.output_edge              = normal_pins_i.output_edge;
      set_d.offset_magnitude         = 8'h00;
      set_d.offset_negative          = 1'b0;
      set_d.phase_adjust_enable      = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_q <= '0;
    end else begin
      set_q <= set_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs: nothing here returns contents to the serial pins
  // ----------------------------------------------------------------
  assign settings_o       = set_q;                     // [R2]
  assign full_scale_o     = ext_mode ? fullsc_q : scw_pkg::FULLSC_RESET;
  assign fine_phase_o     = ext_mode ? fine_q : scw_pkg::FINE_RESET;
  assign coarse_phase_o   = ext_mode ? coarse_q : scw_pkg::COARSE_RESET;
  assign capture_buffer_o = ext_mode ? capbuf_q : scw_pkg::CAPBUF_RESET;
  assign write_pulse_o    = write_q;

  // power_down_i is accepted for completeness; registers hold regardless
  logic unused_pd;
  assign unused_pd = power_down_i;

endmodule // scw_serial_config

// ### design/scw_pkg.sv
// package: frame layout, register addresses, field positions and reset values
package scw_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS  = 32;
  localparam int          HDR_BITS    = 12;
  localparam int          ADDR_BITS   = 4;
  localparam int          DATA_BITS   = 16;
  localparam logic [11:0] HDR_PATTERN = 12'h001;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG   = 4'h1;
  localparam logic [3:0] ADDR_OFFSET   = 4'h2;
  localparam logic [3:0] ADDR_FULLSCL  = 4'h3;
  localparam logic [3:0] ADDR_FINE_PH  = 4'hD;
  localparam logic [3:0] ADDR_COARS_PH = 4'hE;
  localparam logic [3:0] ADDR_CAPBUF   = 4'hF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_DIFF_RST_BIT  = 14;
  localparam int CFG_TRIM_DIS_BIT  = 13;
  localparam int CFG_DUTY_STAB_BIT = 12;
  localparam int CFG_DDR_PHASE_BIT = 11;
  localparam int CFG_SDR_SEL_BIT   = 10;
  localparam int CFG_OUT_EDGE_BIT  = 8;
  localparam int OFS_MAG_LSB       = 8;
  localparam int OFS_SIGN_BIT      = 7;
  localparam int CRS_ENABLE_BIT    = 15;

  // ----------------------------------------------------------------
  // power-on values (fixed-one positions read as written ones)
  // ----------------------------------------------------------------
  localparam logic [15:0] CONFIG_RESET = 16'h9EFF;
  localparam logic [15:0] OFFSET_RESET = 16'h007F;
  localparam logic [15:0] FULLSC_RESET = 16'h807F;
  localparam logic [15:0] FINE_RESET   = 16'h007F;
  localparam logic [15:0] COARSE_RESET = 16'h03FF;
  localparam logic [15:0] CAPBUF_RESET = 16'hE7FF;

  // ----------------------------------------------------------------
  // decoded settings seen by the rest of the device
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       diff_clkreset_enable;
    logic       termination_trim_disable;
    logic       duty_cycle_stabilize;
    logic       double_rate_strobe_phase;
    logic       single_rate_select;
    logic       output_edge;
    logic [7:0] offset_magnitude;
    logic       offset_negative;
    logic       phase_adjust_enable;
  } scw_settings_t;

  // normal control mode equivalents
  typedef struct packed {
    logic single_rate_select;
    logic output_edge;
  } scw_pins_t;

endpackage : scw_pkg

// ### testbench/scw_serial_config_props.sv
// checker: port-level properties of the serial configuration write port
`timescale 1ns/10ps

module scw_props_chk (
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // serial, mode and power pins
  input wire logic                   serial_select_n_i,
  input wire logic                   serial_clk_i,
  input wire logic                   serial_data_in_i,
  input wire logic                   extended_mode_i,
  input wire logic                   power_down_i,
  input wire scw_pkg::scw_pins_t     normal_pins_i,
  // design outputs
  input wire logic [15:0]            full_scale_o,
  input wire logic [15:0]            fine_phase_o,
  input wire logic [15:0]            coarse_phase_o,
  input wire logic [15:0]            capture_buffer_o,
  input wire scw_pkg::scw_settings_t settings_o,
  input wire logic                   write_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] age_q;
  logic [3:0] rise_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // settings reach their defaults a few cycles after reset, so age gates them
  always_ff @(posedge clk_i) begin
    if (rst_i) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || $rose(serial_clk_i)) rise_q <= 4'h0;
    else if (rise_q != 4'hF) rise_q <= rise_q + 4'h1;
  end
  sequence raw_change_s;
    !$stable({full_scale_o, fine_phase_o, coarse_phase_o, capture_buffer_o});
  endsequence
  sequence normal_run_s;
    (!extended_mode_i)[*8];
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  pulse_width_a: assert property (write_pulse_o |=> !write_pulse_o)
    else $error("write pulse longer than one cycle");
  mode_gate_a: assert property (normal_run_s |-> !write_pulse_o)
    else $error("write accepted in normal mode");
  normal_inert_a: assert property (normal_run_s |-> full_scale_o == scw_pkg::FULLSC_RESET
    && coarse_phase_o == scw_pkg::COARSE_RESET) else $error("registers active in normal mode");
  normal_pins_a: assert property (normal_run_s |-> settings_o ==
    (16'h2000 | {4'h0, $past(normal_pins_i), 10'h000})) else $error("normal settings wrong");
  raw_update_a: assert property (raw_change_s |-> write_pulse_o)
    else $error("register changed without a write");
  settings_move_a: assert property (extended_mode_i && age_q == 3'h7
    && !$stable(settings_o) |-> $past(write_pulse_o))
    else $error("settings changed without a write");
  edge_to_pulse_a: assert property (write_pulse_o |-> rise_q inside {[1:8]})
    else $error("write not tied to a serial clock edge");
  coarse_enable_a: assert property (!$stable(coarse_phase_o) |-> write_pulse_o
    ##1 settings_o.phase_adjust_enable == coarse_phase_o[15]) else $error("phase enable wrong");
endmodule // scw_props_chk

bind scw_serial_config scw_props_chk i_props (.clk_i(clk_i), .rst_i(rst_i),
  .serial_select_n_i(serial_select_n_i), .serial_clk_i(serial_clk_i),
  .serial_data_in_i(serial_data_in_i), .extended_mode_i(extended_mode_i),
  .power_down_i(power_down_i), .normal_pins_i(normal_pins_i), .full_scale_o(full_scale_o),
  .fine_phase_o(fine_phase_o), .coarse_phase_o(coarse_phase_o),
  .capture_buffer_o(capture_buffer_o), .settings_o(settings_o), .write_pulse_o(write_pulse_o));

// ### testbench/scw_host_model.sv
// partner: host that shifts frames into the serial configuration port
`timescale 1ns/10ps

module scw_host_model (
  // serial lines toward the device
  output logic sel_n_o,
  output logic sclk_o,
  output logic serial_data_in_o
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    serial_data_in_o = 1'b0;
  end
  // data moves while the clock is low; the clock stands low between frames
  task automatic send(input logic [63:0] bits, input int n, input bit keep);
    sel_n_o = 1'b0;
    #160;
    for (int i = 63; i > 63 - n; i--) begin
      serial_data_in_o = bits[i];
      #160 sclk_o = 1'b1;
      #160 sclk_o = 1'b0;
    end
    if (!keep) begin
      #160 sel_n_o = 1'b1;
      serial_data_in_o = ~serial_data_in_o; // a released line must not keep showing the last bit
      #160; // select stays high long enough for the port to drop a cut frame
    end
  endtask
endmodule // scw_host_model

// ### testbench/test_scw_serial_config.sv
// testbench: frames written through the serial port, checked at the outputs
`timescale 1ns/10ps

module test_scw_serial_config;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   extended_mode_i = 1'b1;
  logic                   power_down_i = 1'b0;
  scw_pkg::scw_pins_t     normal_pins_i = 2'h3;
  logic                   sel_n, sclk, serial_data_in, wp;
  logic [15:0]            fs, fp, cp, cb;
  scw_pkg::scw_settings_t st;
  logic [11:0]            hdr = scw_pkg::HDR_PATTERN;
  logic [3:0]             addrs [5] = '{4'h3, 4'hD, 4'hF, 4'h0, 4'h4};
  int                     fails = 0, samples_checked = 0, pulses = 0, cycles = 0;

  scw_host_model i_host (.sel_n_o(sel_n), .sclk_o(sclk), .serial_data_in_o(serial_data_in));
  scw_serial_config #(.SYNC_STAGES(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .serial_select_n_i(sel_n), .serial_clk_i(sclk), .serial_data_in_i(serial_data_in),
    .extended_mode_i(extended_mode_i), .power_down_i(power_down_i),
    .normal_pins_i(normal_pins_i), .full_scale_o(fs), .fine_phase_o(fp),
    .coarse_phase_o(cp), .capture_buffer_o(cb), .settings_o(st), .write_pulse_o(wp));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (wp === 1'b1) pulses++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (12) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] addr, input logic [15:0] val);
    i_host.send({hdr, addr, val, 32'h0000_0000}, 32, 1'b0);
    settle();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check("defaults", st, 16'h3800);
    check("full scale", fs, scw_pkg::FULLSC_RESET);
    // two frames with select held low: the 33rd edge opens the second
    i_host.send({hdr, 4'h1, 16'hFFFF, hdr, 4'h2, 16'hA5FF}, 64, 1'b0);
    settle();
    check("back to back", st, 16'hFE96);
    check("pulses", 16'(pulses), 16'h0002);
    wr(4'hE, 16'h83FF);
    check("coarse", cp, 16'h83FF);
    check("enable", st, 16'hFE97);
    foreach (addrs[i]) wr(addrs[i], 16'h1200 + 16'(i));
    check("fs", fs, 16'h1200);
    check("fine", fp, 16'h1201);
    check("capture", cb, 16'h1202);
    check("reserved", st, 16'hFE97);
    check("pulses", 16'(pulses), 16'h0008);
    power_down_i = 1'b1;
    i_host.send({12'h003, 4'h1, 16'h9DFF, 32'h0000_0000}, 32, 1'b0);
    settle();
    check("bad header", st, 16'hFE97);
    check("pulses", 16'(pulses), 16'h0008);
    power_down_i = 1'b0;
    i_host.send({hdr, 4'h1, 16'h9EFF, 32'h0000_0000}, 20, 1'b0);
    wr(4'h1, 16'h9EFF);
    check("after abort", st, 16'h3A97);
    check("pulses", 16'(pulses), 16'h0009);
    rst_i = 1'b1;
    extended_mode_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    wr(4'hE, 16'h83FF);
    check("normal coarse", cp, scw_pkg::COARSE_RESET);
    check("normal settings", st, 16'h2C00);
    normal_pins_i = 2'h1;
    settle();
    check("normal pins", st, 16'h2400);
    check("pulses", 16'(pulses), 16'h0009);
    close_out();
  end
endmodule // test_scw_serial_config
